// ===== src/asc_pkg.sv
// Purpose: shared constants and carriers for alarm select and command control
// Assumes: 200 MHz reference clock, synchronous active-high reset
// Notes: parameter values arrive from the serial or panel front end
package asc_pkg;

   // ==========================================================
   // command word layout
   localparam int CMD_W = 16;
   localparam int CMD_LOCAL_SP_BIT = 1;
   localparam int CMD_ENABLE_BIT = 2;
   localparam int CMD_LOCAL_ILIM_BIT = 4;
   localparam logic [15:0] CMD_RESET = 16'h0000;

   // ==========================================================
   // alarm selection: bit0 heater break, bit1 short, bit2 current limit,
   // bit3 watchdog (communication only)
   localparam int SEL_HB_BIT = 0;
   localparam int SEL_SC_BIT = 1;
   localparam int SEL_IL_BIT = 2;
   localparam int SEL_WD_BIT = 3;
   localparam logic [3:0] ALARM_SEL_RESET = 4'h1;

   // ==========================================================
   // analog input signal types and functions
   typedef enum logic [1:0] {
      ASC_AIN_VOLTAGE_OR_POTENTIOMETER_RANGE = 2'h1,
      ASC_AIN_4_20MA = 2'h2,
      ASC_AIN_0_20MA = 2'h3
   } asc_ain_type_t;
   localparam asc_ain_type_t AIN_TYPE_RESET =
      ASC_AIN_VOLTAGE_OR_POTENTIOMETER_RANGE;

   typedef enum logic [1:0] {
      ASC_AIN2_ILIM = 2'h0,
      ASC_AIN2_EXT_FB = 2'h1,
      ASC_AIN2_POWER_SP = 2'h3
   } asc_ain2_fn_t;
   localparam asc_ain2_fn_t AIN2_FN_RESET = ASC_AIN2_ILIM;

   // ==========================================================
   // ranges (tenths of percent, volts, minutes, tenths of ampere)
   localparam logic [9:0] AIN_MAX = 10'h3e8;
   localparam logic [9:0] VOLT_MAX = 10'h3ff;
   localparam logic [13:0] MINUTES_MAX = 14'h270f;
   localparam logic [13:0] BAKE_I_MAX = 14'h270f;
   localparam logic [13:0] BAKE_RESET = 14'h0000;

   // ==========================================================
   // cycle time in 50 ms units
   localparam int CYCLE_UNIT_MS = 50;
   localparam int CLK_KHZ = 200000;
   localparam int CYCLE_UNIT_CLKS = CYCLE_UNIT_MS * CLK_KHZ;
   localparam logic [7:0] CYCLE_TIME_RESET = 8'h1e;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic heater_break;
      logic short_thyristor;
      logic current_limit;
      logic watchdog;
      logic over_temp;
   } asc_faults_t;

   typedef struct packed {
      logic wr;
      logic from_comm;
      logic [3:0] sel;
   } asc_sel_wr_t;

endpackage : asc_pkg

// ===== src/asc_tick.sv
// Purpose: enable pulse divider for the cycle-time unit
// Assumes: single clock, synchronous reset
// Notes: one-cycle pulse every DIV clocks
module asc_tick
   import asc_pkg::*;
#(
   parameter int DIV = CYCLE_UNIT_CLKS
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   output logic tick_o
);

   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } asc_tick_st_t;

   asc_tick_st_t st;
   asc_tick_st_t next_st;

   // ==========================================================
   // count down and pulse
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == 32'h0) begin
         next_st.cnt = 32'(DIV - 1);
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt - 32'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;

endmodule : asc_tick

// ===== src/asc_ctrl.sv
// Purpose: alarm select, command decode, enable gating, parameter hold
// Assumes: fault and pin inputs are asynchronous and are synchronised here
// Notes: parameter writes come from the serial or panel front end
// Functional notes
// R1 - heat sink over-temperature always alarms
// R2 - output energized normally, dropped on alarm
// R3 - unselected faults neither alarm nor record
// R4 - eight subsets of three faults, ORed over-temperature
// R5 - watchdog selections only from communication link
// R6 - current-limit selections only on such variants
// R7 - analog input 1 type codes 1,2,3
// R8 - analog readings percent, read only, capped
// R9 - analog input 2 has one function
// R10 - command bits 1,2,4 decoded, others ignored
// R11 - bit 4 picks current limit source
// R12 - bit 2 enables unless input assigned enable
// R13 - secondary port read-write: bit 1 alone
// R14 - secondary port read-write: input and bit 2
// R15 - host writes command as sum 0..22
// R16 - cycle time 8-bit, 50 ms units, default 30
// R17 - line voltage read only, to 1023
// R18 - bakeout times in minutes, default zero
// R19 - bakeout current tenths of ampere, default zero
// R20 - registered OR of masked faults
// R21 - digital input local when on
module asc_ctrl
   import asc_pkg::*;
#(
   parameter bit HAS_ILIM = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire asc_faults_t faults_i,
   input wire logic power_ok_i,
   input wire logic cmd_wr_i,
   input wire logic [15:0] cmd_wdata_i,
   output logic [15:0] cmd_rdata_o,
   input wire asc_sel_wr_t sel_wr_i,
   output logic [3:0] alarm_sel_o,
   input wire logic ain1_type_wr_i,
   input wire logic [1:0] ain1_type_i,
   output logic [1:0] ain1_type_o,
   input wire logic ain2_fn_wr_i,
   input wire logic [1:0] ain2_fn_i,
   output logic [1:0] ain2_fn_o,
   input wire logic [9:0] ain1_raw_i,
   input wire logic [9:0] ain2_raw_i,
   output logic [9:0] ain1_value_o,
   output logic [9:0] ain2_value_o,
   input wire logic [9:0] volt_raw_i,
   output logic [9:0] line_volt_o,
   input wire logic cycle_wr_i,
   input wire logic [7:0] cycle_time_i,
   output logic [7:0] cycle_time_o,
   output logic cycle_tick_o,
   input wire logic bake_wr_i,
   input wire logic [1:0] bake_sel_i,
   input wire logic [13:0] bake_val_i,
   output logic [13:0] bake_off_time_o,
   output logic [13:0] bake_ramp_time_o,
   output logic [13:0] bake_current_o,
   input wire logic [1:0] din_i,
   input wire logic din_enable_fn_i,
   input wire logic din_locrem_fn_i,
   input wire logic din_sel_i,
   input wire logic port2_rw_i,
   output logic alarm_out_o,
   output logic alarm_latched_o,
   output logic output_enable_o,
   output logic local_setpoint_o,
   output logic local_ilim_o,
   output logic ain2_ilim_o,
   output logic ain2_ext_fb_o,
   output logic ain2_power_sp_o
);

   typedef struct packed {
      asc_faults_t f_s1;
      asc_faults_t f_s2;
      logic [1:0] din_s1;
      logic [1:0] din_s2;
      logic pwr_s1;
      logic pwr_s2;
      logic [15:0] cmd;
      logic [3:0] sel;
      logic [1:0] ain1_type;
      logic [1:0] ain2_fn;
      logic [9:0] ain1_val;
      logic [9:0] ain2_val;
      logic [9:0] volt;
      logic [7:0] cycle_time;
      logic [7:0] cycle_cnt;
      logic cycle_tick;
      logic [13:0] bake_off;
      logic [13:0] bake_ramp;
      logic [13:0] bake_cur;
      logic alarm_out;
      logic alarm_latched;
      logic out_en;
      logic loc_sp;
      logic loc_il;
      logic a2_il;
      logic a2_fb;
      logic a2_ps;
   } asc_st_t;

   asc_st_t st;
   asc_st_t next_st;
   logic unit_tick;
   logic [3:0] sel_req;
   logic fault_hit;
   logic din_val;
   logic [9:0] clip_a1;
   logic [9:0] clip_a2;

   // ==========================================================
   // 50 ms unit divider
   asc_tick #(
      .DIV(CYCLE_UNIT_CLKS)
   ) u_tick (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .tick_o(unit_tick)
   );

   // ==========================================================
   // next-state logic
   always_comb begin
      next_st = st;
      // two-stage synchronisers for pins and fault inputs
      next_st.f_s1 = faults_i;
      next_st.f_s2 = st.f_s1;
      next_st.din_s1 = din_i;
      next_st.din_s2 = st.din_s1;
      next_st.pwr_s1 = power_ok_i;
      next_st.pwr_s2 = st.pwr_s1;

      // command word, stored whole, decoded below
      if (cmd_wr_i) begin
         next_st.cmd = cmd_wdata_i; // R15
      end

      // alarm selection write, filtered
      sel_req = sel_wr_i.sel;
      if (!sel_wr_i.from_comm) begin
         sel_req[SEL_WD_BIT] = 1'b0; // R5
      end
      if (!HAS_ILIM) begin
         sel_req[SEL_IL_BIT] = 1'b0; // R6
      end
      if (sel_wr_i.wr) begin
         next_st.sel = sel_req; // R4
      end

      // analog input 1 type, only codes 1..3 accepted
      if (ain1_type_wr_i && ain1_type_i != 2'h0) begin
         next_st.ain1_type = ain1_type_i; // R7
      end
      // analog input 2 function, one of three
      if (ain2_fn_wr_i && ain2_fn_i != 2'h2) begin
         next_st.ain2_fn = ain2_fn_i; // R9
      end

      // read-only readings, capped to full scale
      clip_a1 = (ain1_raw_i > AIN_MAX) ? AIN_MAX : ain1_raw_i;
      clip_a2 = (ain2_raw_i > AIN_MAX) ? AIN_MAX : ain2_raw_i;
      next_st.ain1_val = clip_a1; // R8
      next_st.ain2_val = clip_a2; // R8
      next_st.volt = (volt_raw_i > VOLT_MAX) ? VOLT_MAX : volt_raw_i; // R17

      // cycle time and on-off cycle timer
      if (cycle_wr_i) begin
         next_st.cycle_time = cycle_time_i; // R16
      end
      next_st.cycle_tick = 1'b0;
      if (unit_tick) begin
         if (st.cycle_cnt >= st.cycle_time) begin
            next_st.cycle_cnt = 8'h0;
            next_st.cycle_tick = 1'b1; // R16
         end else begin
            next_st.cycle_cnt = st.cycle_cnt + 8'h1;
         end
      end

      // bakeout parameters, only on current-limit variants
      if (HAS_ILIM && bake_wr_i) begin
         case (bake_sel_i)
            2'h0: begin
               if (bake_val_i <= MINUTES_MAX) begin
                  next_st.bake_off = bake_val_i; // R18
               end
            end
            2'h1: begin
               if (bake_val_i <= MINUTES_MAX) begin
                  next_st.bake_ramp = bake_val_i; // R18
               end
            end
            2'h2: begin
               if (bake_val_i <= BAKE_I_MAX) begin
                  next_st.bake_cur = bake_val_i; // R19
               end
            end
            default: begin
            end
         endcase
      end

      // masked faults, over-temperature always counts
      fault_hit = st.f_s2.over_temp // R1
         | (st.f_s2.heater_break & st.sel[SEL_HB_BIT]) // R3
         | (st.f_s2.short_thyristor & st.sel[SEL_SC_BIT]) // R3
         | (st.f_s2.current_limit & st.sel[SEL_IL_BIT]) // R20
         | (st.f_s2.watchdog & st.sel[SEL_WD_BIT]); // R5
      // energized when powered and no alarm
      next_st.alarm_out = st.pwr_s2 & ~fault_hit; // R2
      // only over-temperature and selected faults are recorded
      next_st.alarm_latched = fault_hit; // R3

      // local/remote setpoint
      din_val = st.din_s2[din_sel_i];
      if (din_locrem_fn_i && !port2_rw_i) begin
         next_st.loc_sp = din_val; // R21
      end else begin
         next_st.loc_sp = st.cmd[CMD_LOCAL_SP_BIT]; // R13
      end

      // output enable gating
      if (!din_enable_fn_i) begin
         next_st.out_en = st.cmd[CMD_ENABLE_BIT]; // R12
      end else if (port2_rw_i) begin
         next_st.out_en = din_val & st.cmd[CMD_ENABLE_BIT]; // R14
      end else begin
         next_st.out_en = din_val;
      end

      // current-limit source
      next_st.loc_il = st.cmd[CMD_LOCAL_ILIM_BIT]; // R11
      next_st.a2_il = (st.ain2_fn == ASC_AIN2_ILIM) &
         ~st.cmd[CMD_LOCAL_ILIM_BIT]; // R11
      next_st.a2_fb = (st.ain2_fn == ASC_AIN2_EXT_FB); // R9
      next_st.a2_ps = (st.ain2_fn == ASC_AIN2_POWER_SP); // R9
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.cmd <= CMD_RESET;
         st.sel <= ALARM_SEL_RESET; // R6
         st.ain1_type <= AIN_TYPE_RESET; // R7
         st.ain2_fn <= AIN2_FN_RESET; // R9
         st.cycle_time <= CYCLE_TIME_RESET; // R16
         st.bake_off <= BAKE_RESET; // R18
         st.bake_ramp <= BAKE_RESET; // R18
         st.bake_cur <= BAKE_RESET; // R19
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs straight from state
   assign cmd_rdata_o = st.cmd; // R10
   assign alarm_sel_o = st.sel;
   assign ain1_type_o = st.ain1_type;
   assign ain2_fn_o = st.ain2_fn;
   assign ain1_value_o = st.ain1_val;
   assign ain2_value_o = st.ain2_val;
   assign line_volt_o = st.volt;
   assign cycle_time_o = st.cycle_time;
   assign cycle_tick_o = st.cycle_tick;
   assign bake_off_time_o = st.bake_off;
   assign bake_ramp_time_o = st.bake_ramp;
   assign bake_current_o = st.bake_cur;
   assign alarm_out_o = st.alarm_out; // R20
   assign alarm_latched_o = st.alarm_latched;
   assign output_enable_o = st.out_en;
   assign local_setpoint_o = st.loc_sp;
   assign local_ilim_o = st.loc_il;
   assign ain2_ilim_o = st.a2_il;
   assign ain2_ext_fb_o = st.a2_fb;
   assign ain2_power_sp_o = st.a2_ps;

endmodule : asc_ctrl

// ===== bench/asc_host_model.sv
// Purpose: host side writing the command word and alarm selection
// Assumes: writes launched on falling edges, one cycle long
// Notes: released data is inverted, never left stale
module asc_host_model
   import asc_pkg::*;
(
   input wire logic ref_clk_i,
   output logic cmd_wr_o,
   output logic [15:0] cmd_wdata_o,
   output asc_sel_wr_t sel_wr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // write tasks
   initial begin
      cmd_wr_o = 1'h0;
      cmd_wdata_o = 16'h0;
      sel_wr_o = '0;
   end
   // command as a sum of features, stray bits only when asked
   task automatic write_cmd(logic [4:0] sum, logic [15:0] junk);
      @(negedge ref_clk_i);
      cmd_wr_o = 1'h1;
      cmd_wdata_o = {11'h0, sum & 5'h16} | (junk & 16'hffe9);
      @(negedge ref_clk_i);
      cmd_wr_o = 1'h0;
      cmd_wdata_o = ~cmd_wdata_o;
   endtask : write_cmd
   // selection write, comm flags it as sent over the link
   task automatic write_sel(logic comm, logic [3:0] sel);
      @(negedge ref_clk_i);
      sel_wr_o = '{1'h1, comm, sel};
      @(negedge ref_clk_i);
      sel_wr_o = '{1'h0, 1'h0, ~sel};
   endtask : write_sel
endmodule : asc_host_model

// ===== bench/asc_ctrl_assertions.sv
// Purpose: port checks for alarm select and command control
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every asc_ctrl
module asc_ctrl_assertions
   import asc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire asc_faults_t faults_i,
   input wire logic power_ok_i,
   input wire logic cmd_wr_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic [15:0] cmd_rdata_o,
   input wire asc_sel_wr_t sel_wr_i,
   input wire logic [3:0] alarm_sel_o,
   input wire logic din_enable_fn_i,
   input wire logic port2_rw_i,
   input wire logic alarm_out_o,
   input wire logic output_enable_o,
   input wire logic local_setpoint_o,
   input wire logic local_ilim_o,
   input wire logic alarm_latched_o,
   input wire logic cycle_tick_o
);
   // ==========================================
   // faults in selection bit order
   logic [3:0] fv;
   assign fv = {faults_i.watchdog, faults_i.current_limit,
      faults_i.short_thyristor, faults_i.heater_break};
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   ot_alarm_a: assert property (
      faults_i.over_temp [*3] |=> !alarm_out_o) else $error("ot kept on");
   ot_latch_a: assert property (
      faults_i.over_temp [*3] |=> alarm_latched_o)
      else $error("ot not recorded");
   tick_pulse_a: assert property (
      cycle_tick_o |=> !cycle_tick_o) else $error("cycle tick too long");
   clean_on_a: assert property (
      (power_ok_i && !faults_i.over_temp && (fv & alarm_sel_o) == 4'h0) [*3]
      |=> alarm_out_o) else $error("clean output off");
   sel_fault_a: assert property (
      ((fv & alarm_sel_o) != 4'h0) [*3] |=> !alarm_out_o)
      else $error("selected fault kept on");
   cmd_store_a: assert property (
      cmd_wr_i |=> cmd_rdata_o == $past(cmd_wdata_i)) else $error("cmd");
   enable_cmd_a: assert property (
      cmd_wr_i ##1 (!cmd_wr_i && !din_enable_fn_i) |=>
      output_enable_o == $past(cmd_wdata_i[CMD_ENABLE_BIT], 2))
      else $error("enable");
   ilim_src_a: assert property (
      cmd_wr_i ##1 !cmd_wr_i |=>
      local_ilim_o == $past(cmd_wdata_i[CMD_LOCAL_ILIM_BIT], 2))
      else $error("ilim source");
   port2_loc_a: assert property (
      cmd_wr_i ##1 (!cmd_wr_i && port2_rw_i) |=>
      local_setpoint_o == $past(cmd_wdata_i[CMD_LOCAL_SP_BIT], 2))
      else $error("port2 local");
   panel_wd_a: assert property (
      sel_wr_i.wr && !sel_wr_i.from_comm |=> !alarm_sel_o[SEL_WD_BIT])
      else $error("panel watchdog");
endmodule : asc_ctrl_assertions
bind asc_ctrl asc_ctrl_assertions chk_i (.*);

// ===== bench/asc_ctrl_tb.sv
// Purpose: self-checking bench for asc_ctrl
// Assumes: host writes via asc_host_model, the rest driven here
// Notes: driver queues expectations, a monitor compares them
module asc_ctrl_tb
   import asc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int i; logic [15:0] v;} asc_note_t;
   // ==========================================
   // ports and bench state
   logic ref_clk_i = 1'h0, rst_i = 1'h1, power_ok_i = 1'h0, cmd_wr_i;
   logic ain1_type_wr_i = 1'h0, ain2_fn_wr_i = 1'h0, cycle_wr_i = 1'h0;
   logic bake_wr_i = 1'h0, din_enable_fn_i = 1'h0, din_locrem_fn_i = 1'h0;
   logic port2_rw_i = 1'h0, din_sel_i = 1'h0, cycle_tick_o, alarm_out_o;
   logic [1:0] ain1_type_i = 2'h0, ain2_fn_i = 2'h0, bake_sel_i = 2'h0;
   logic [1:0] din_i = 2'h0, ain1_type_o, ain2_fn_o;
   logic [7:0] cycle_time_i = 8'h0, cycle_time_o;
   logic [9:0] ain1_raw_i = 10'h0, ain2_raw_i = 10'h0, volt_raw_i = 10'h0;
   logic [9:0] ain1_value_o, ain2_value_o, line_volt_o;
   logic [13:0] bake_val_i = 14'h0, bake_off_time_o, bake_ramp_time_o;
   logic [13:0] bake_current_o;
   logic [15:0] cmd_wdata_i, cmd_rdata_o, e1, e2;
   logic [3:0] alarm_sel_o;
   logic alarm_latched_o, output_enable_o, local_setpoint_o, local_ilim_o;
   logic ain2_ilim_o, ain2_ext_fb_o, ain2_power_sp_o;
   logic [31:0] seed = 32'hb9f9, r;
   asc_faults_t faults_i = '0;
   asc_sel_wr_t sel_wr_i;
   logic [15:0] obs [18];
   string nm [18] = '{"cmd", "sel", "ain1_type", "ain2_fn", "ain1", "volt",
      "cycle", "bake_off", "bake_ramp", "bake_i", "alarm", "enable",
      "local_sp", "local_ilim", "ain2", "latched", "ain2_route",
      "cycle_tick"};
   logic [15:0] rv [10] = '{16'h0, 16'h1, 16'h1, 16'h0, 16'h0, 16'h0,
      16'h1e, 16'h0, 16'h0, 16'h0};
   logic [4:0] sums [8] = '{5'h0, 5'h2, 5'h4, 5'h6, 5'h10, 5'h12, 5'h14,
      5'h16};
   asc_note_t notes [$];
   asc_note_t n;
   event look;
   int fails = 0;
   int comparisons = 0;
   asc_ctrl uut (.*);
   asc_host_model host (.ref_clk_i(ref_clk_i), .cmd_wr_o(cmd_wr_i),
      .cmd_wdata_o(cmd_wdata_i), .sel_wr_o(sel_wr_i));
   // clock and observed outputs
   always #2.5 ref_clk_i = ~ref_clk_i;
   always_comb obs = '{cmd_rdata_o, 16'(alarm_sel_o), 16'(ain1_type_o),
      16'(ain2_fn_o), 16'(ain1_value_o), 16'(line_volt_o), 16'(cycle_time_o),
      16'(bake_off_time_o), 16'(bake_ramp_time_o), 16'(bake_current_o),
      16'(alarm_out_o), 16'(output_enable_o), 16'(local_setpoint_o),
      16'(local_ilim_o), 16'(ain2_value_o), 16'(alarm_latched_o),
      16'({ain2_power_sp_o, ain2_ext_fb_o, ain2_ilim_o}),
      16'(cycle_tick_o)};
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic tick(int k);
      repeat (k) @(negedge ref_clk_i);
   endtask : tick
   task automatic chk(int i, logic [15:0] v);
      notes.push_back('{i, v});
      -> look;
   endtask : chk
   task automatic end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   // monitor: oldest note against the live output
   always @(look) begin
      while (notes.size() != 0) begin
         n = notes.pop_front();
         comparisons++;
         if (obs[n.i] !== n.v) begin
            fails++;
            $display("unexpected %s exp %h got %h", nm[n.i], n.v, obs[n.i]);
         end
      end
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fails++;
      end_sim();
   end
   // ==========================================
   // scenarios
   initial begin
      tick(5);
      rst_i = 1'h0;
      tick(1);
      for (int i = 0; i < 10; i++) chk(i, rv[i]);
      chk(16, 16'h1);
      foreach (sums[j]) begin
         r = xs();
         host.write_cmd(sums[j], r[15:0]);
         tick(1);
         chk(0, {r[15:5], sums[j][4], r[3], sums[j][2:1], r[0]});
         chk(11, 16'(sums[j][2]));
         chk(12, 16'(sums[j][1]));
         chk(13, 16'(sums[j][4]));
         chk(16, 16'(!sums[j][4]));
      end
      power_ok_i = 1'h1;
      for (int s = 0; s < 16; s++) begin
         host.write_sel(1'h1, 4'(s));
         chk(1, 16'(s));
         for (int k = 0; k < 5; k++) begin
            faults_i = 5'h10 >> k;
            tick(4);
            chk(10, k == 4 ? 16'h0 : 16'(!s[k]));
            chk(15, k == 4 ? 16'h1 : 16'(s[k]));
         end
      end
      host.write_sel(1'h0, 4'hf);
      chk(1, 16'h7);
      faults_i = '0;
      power_ok_i = 1'h0;
      tick(4);
      chk(10, 16'h0);
      power_ok_i = 1'h1;
      tick(4);
      chk(10, 16'h1);
      r = xs();
      din_sel_i = r[0];
      din_enable_fn_i = 1'h1;
      port2_rw_i = 1'h1;
      host.write_cmd(5'h4, 16'h0);
      for (int d = 0; d < 2; d++) begin
         // the assigned input carries the level, the other its inverse
         din_i = din_sel_i ? {d[0], !d[0]} : {!d[0], d[0]};
         tick(4);
         chk(11, 16'(d));
      end
      port2_rw_i = 1'h0;
      host.write_cmd(5'h0, 16'h0);
      tick(4);
      chk(11, 16'h1);
      din_enable_fn_i = 1'h0;
      din_locrem_fn_i = 1'h1;
      for (int p = 0; p < 2; p++) begin
         port2_rw_i = p[0];
         tick(4);
         chk(12, 16'(!p[0]));
      end
      for (int i = 0; i < 16; i++) begin
         r = xs();
         ain1_raw_i = i == 0 ? 10'h3e9 : r[9:0];
         ain2_raw_i = i == 0 ? 10'h3ff : r[19:10];
         volt_raw_i = r[29:20];
         tick(2);
         chk(4, 16'(ain1_raw_i > AIN_MAX ? AIN_MAX : ain1_raw_i));
         chk(14, 16'(ain2_raw_i > AIN_MAX ? AIN_MAX : ain2_raw_i));
         chk(5, 16'(volt_raw_i));
      end
      e1 = 16'h1;
      e2 = 16'h0;
      for (int c = 3; c >= 0; c--) begin
         ain1_type_i = 2'(c);
         ain2_fn_i = 2'(c);
         ain1_type_wr_i = 1'h1;
         ain2_fn_wr_i = 1'h1;
         tick(1);
         ain1_type_wr_i = 1'h0;
         ain2_fn_wr_i = 1'h0;
         tick(1);
         e1 = c == 0 ? e1 : 16'(c);
         e2 = c == 2 ? e2 : 16'(c);
         chk(2, e1);
         chk(3, e2);
         chk(16, 16'({e2 == 16'h3, e2 == 16'h1, e2 == 16'h0}));
      end
      for (int b = 0; b < 6; b++) begin
         bake_sel_i = 2'(b % 3);
         bake_val_i = b < 3 ? 14'h270f : 14'h2710;
         cycle_time_i = 8'hff;
         bake_wr_i = 1'h1;
         cycle_wr_i = 1'h1;
         tick(1);
         bake_wr_i = 1'h0;
         cycle_wr_i = 1'h0;
         tick(1);
         chk(7 + b % 3, 16'h270f);
         chk(6, 16'hff);
      end
      // mid-run reset, zero cycle time taken on the first edge
      ain1_raw_i = 10'h0;
      volt_raw_i = 10'h0;
      rst_i = 1'h1;
      tick(5);
      rst_i = 1'h0;
      cycle_time_i = 8'h0;
      cycle_wr_i = 1'h1;
      tick(1);
      cycle_wr_i = 1'h0;
      for (int i = 0; i < 10; i++) chk(i, i == 6 ? 16'h0 : rv[i]);
      tick(1);
      chk(17, 16'h1);
      tick(1);
      chk(17, 16'h0);
      tick(2);
      end_sim();
   end
endmodule : asc_ctrl_tb
